// >>> telemetry_pkg.sv
// Package for the telemetry command bank: command codes, field positions,
// reset values and ADC selection codes.
// Assumes a command-level front end that decodes the serial protocol.
package telemetry_pkg;
  localparam logic [7:0] CMD_VIN        = 8'h88;
  localparam logic [7:0] CMD_IIN_TOTAL  = 8'h89;
  localparam logic [7:0] CMD_VOUT       = 8'h8B;
  localparam logic [7:0] CMD_IOUT       = 8'h8C;
  localparam logic [7:0] CMD_TEMP_EXT   = 8'h8D;
  localparam logic [7:0] CMD_TEMP_DIE   = 8'h8E;
  localparam logic [7:0] CMD_DUTY       = 8'h94;
  localparam logic [7:0] CMD_FREQ       = 8'h95;
  localparam logic [7:0] CMD_POUT       = 8'h96;
  localparam logic [7:0] CMD_IOUT_MAX   = 8'hD7;
  localparam logic [7:0] CMD_ADC_SEL    = 8'hD8;
  localparam logic [7:0] CMD_FAST_STAT  = 8'hDA;
  localparam logic [7:0] CMD_VOUT_MAX   = 8'hDD;
  localparam logic [7:0] CMD_VIN_MAX    = 8'hDE;
  localparam logic [7:0] CMD_TEXT_MAX   = 8'hDF;
  localparam logic [7:0] CMD_IIN_CHAN   = 8'hED;
  localparam logic [7:0] CMD_TDIE_MAX   = 8'hF4;
  // No code is printed for the information word; this one is a free slot.
  localparam logic [7:0] CMD_INFO       = 8'hB6;
  localparam int         ECC_BIT        = 5;
  localparam logic [7:0] ADC_SEL_RESET  = 8'h00;
  localparam logic [7:0] ADC_SEL_RR     = 8'h00;
  localparam logic [7:0] ADC_SEL_SHORT  = 8'h0D;
  localparam logic [7:0] ADC_SEL_DIE    = 8'h04;
  localparam logic [7:0] FAST_MASK      = 8'h0F;
  localparam logic [15:0] PEAK_RESET    = 16'h0000;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
endpackage

// >>> telemetry_bank.sv
// Telemetry command bank: holds readings, peaks, ADC select and fast status.
// Assumes the serial front end hands over decoded word reads and byte writes,
// one cycle each, and a measurement engine that delivers raw results.
`timescale 1ns/1ns
module telemetry_bank
  import telemetry_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        page,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic        clear_maxima_command,
  input  wire logic        meas_valid,
  input  wire logic [3:0]  meas_kind,
  input  wire logic        meas_chan,
  input  wire logic [15:0] meas_value,
  input  wire logic [15:0] meas_aux,
  input  wire logic [15:0] input_current_offset0,
  input  wire logic [15:0] input_current_offset1,
  input  wire logic        ecc_update,
  input  wire logic        ecc_clean,
  output logic             rsp_valid,
  output logic [7:0]       rsp_lo,
  output logic [7:0]       rsp_hi,
  output logic [7:0]       adc_select_eff,
  output logic             invalid_data_flag
);
  // Measurement kinds delivered by the engine.
  localparam logic [3:0] K_VIN  = 4'h0;
  localparam logic [3:0] K_VOUT = 4'h1;
  localparam logic [3:0] K_IOUT = 4'h2;
  localparam logic [3:0] K_TEXT = 4'h3;
  localparam logic [3:0] K_TDIE = 4'h4;
  localparam logic [3:0] K_DUTY = 4'h5;
  localparam logic [3:0] K_FREQ = 4'h6;

  typedef struct packed {
    logic [15:0]      vin;
    logic [15:0]      freq;
    logic [15:0]      tdie;
    logic [1:0][15:0] vout;
    logic [1:0][15:0] iout;
    logic [1:0][15:0] text;
    logic [1:0][15:0] duty;
    logic [1:0][15:0] iin;
    logic [1:0][15:0] pout;
    logic [1:0][15:0] vout_max;
    logic [1:0][15:0] iout_max;
    logic [1:0][15:0] text_max;
    logic [15:0]      vin_max;
    logic [15:0]      tdie_max;
    logic [7:0]       adc_sel;
    logic [7:0]       fast_stat;
    logic             ecc_ok;
    logic             rsp_valid;
    logic [15:0]      rsp;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  function automatic logic sel_valid(input logic [7:0] s);
    case (s)
      8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h08,
      8'h09, 8'h0A, 8'h0C, 8'h0D: sel_valid = 1'b1;
      default: sel_valid = 1'b0;
    endcase
  endfunction

  // Linear products are scaled by truncating the low half; the exact
  // exponent bookkeeping lives in the arithmetic engine upstream.
  function automatic logic [15:0] mul_hi(input logic [15:0] a,
                                         input logic [15:0] b);
    logic [31:0] p;
    p = a * b;
    mul_hi = p[31:16];
  endfunction

  logic [15:0] rd_word;
  logic        sel_ok;

  always_comb begin
    sel_ok = sel_valid(st_ff.adc_sel);
    rd_word = ZERO_WORD;
    case (cmd_code)
      CMD_VIN:       rd_word = st_ff.vin;
      CMD_VOUT:      rd_word = st_ff.vout[page];
      CMD_IIN_TOTAL: rd_word = st_ff.iin[0] + st_ff.iin[1];
      CMD_IIN_CHAN:  rd_word = st_ff.iin[page];
      CMD_IOUT:      rd_word = st_ff.iout[page];
      CMD_TEMP_EXT:  rd_word = st_ff.text[page];
      CMD_TEMP_DIE:  rd_word = st_ff.tdie;
      CMD_DUTY:      rd_word = st_ff.duty[page];
      CMD_FREQ:      rd_word = st_ff.freq;
      CMD_POUT:      rd_word = st_ff.pout[page];
      CMD_VOUT_MAX:  rd_word = st_ff.vout_max[page];
      CMD_VIN_MAX:   rd_word = st_ff.vin_max;
      CMD_IOUT_MAX:  rd_word = st_ff.iout_max[page];
      CMD_TEXT_MAX:  rd_word = st_ff.text_max[page];
      CMD_TDIE_MAX:  rd_word = st_ff.tdie_max;
      CMD_ADC_SEL:   rd_word = {8'h00, st_ff.adc_sel};
      CMD_FAST_STAT: rd_word = {8'h00, st_ff.fast_stat};
      CMD_INFO:      rd_word = 16'(st_ff.ecc_ok) << ECC_BIT;
      default:       rd_word = ZERO_WORD;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp_valid = 1'b0;
    if (cmd_valid && !cmd_write) begin
      nxt_st.rsp_valid = 1'b1;
      nxt_st.rsp = rd_word;
    end
    // Only the two byte registers accept writes; all words ignore them.
    if (cmd_valid && cmd_write && cmd_code == CMD_ADC_SEL) begin
      nxt_st.adc_sel = cmd_wdata;
    end
    if (cmd_valid && cmd_write && cmd_code == CMD_FAST_STAT) begin
      nxt_st.fast_stat = st_ff.fast_stat & ~cmd_wdata;
    end
    if (clear_maxima_command) begin
      nxt_st.vout_max = '0;
      nxt_st.iout_max = '0;
      nxt_st.text_max = '0;
      nxt_st.vin_max  = PEAK_RESET;
      nxt_st.tdie_max = PEAK_RESET;
    end
    if (meas_valid) begin
      case (meas_kind)
        K_VIN: begin
          nxt_st.vin = meas_value;
          if (meas_value > nxt_st.vin_max) nxt_st.vin_max = meas_value;
        end
        K_VOUT: begin
          nxt_st.vout[meas_chan] = meas_value;
          if (meas_value > nxt_st.vout_max[meas_chan])
            nxt_st.vout_max[meas_chan] = meas_value;
          // A correlated pair carries the current in meas_aux.
          nxt_st.pout[meas_chan] = mul_hi(meas_value, meas_aux);
          if (st_ff.adc_sel == ADC_SEL_SHORT)
            nxt_st.fast_stat[{meas_chan, 1'b0}] = 1'b1;
        end
        K_IOUT: begin
          nxt_st.iout[meas_chan] = meas_value;
          if (meas_value > nxt_st.iout_max[meas_chan])
            nxt_st.iout_max[meas_chan] = meas_value;
          nxt_st.iin[meas_chan] = (meas_chan ? input_current_offset1
                                  : input_current_offset0)
                                  + mul_hi(meas_value,
                                           st_ff.duty[meas_chan]);
          if (st_ff.adc_sel == ADC_SEL_SHORT)
            nxt_st.fast_stat[{meas_chan, 1'b1}] = 1'b1;
        end
        K_TEXT: begin
          nxt_st.text[meas_chan] = meas_value;
          if (meas_value > nxt_st.text_max[meas_chan])
            nxt_st.text_max[meas_chan] = meas_value;
        end
        K_TDIE: begin
          nxt_st.tdie = meas_value;
          if (meas_value > nxt_st.tdie_max) nxt_st.tdie_max = meas_value;
        end
        K_DUTY: nxt_st.duty[meas_chan] = meas_value;
        K_FREQ: nxt_st.freq = meas_value;
        default: ;
      endcase
    end
    // The new conversion wins over a clear in the same cycle.
    nxt_st.fast_stat = nxt_st.fast_stat & FAST_MASK;
    if (ecc_update) nxt_st.ecc_ok = ecc_clean;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.adc_sel <= ADC_SEL_RESET;
      // Power-on counts as a clean restore until the engine reports.
      st_ff.ecc_ok <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp_valid = st_ff.rsp_valid;
  assign rsp_lo = st_ff.rsp[7:0];
  assign rsp_hi = st_ff.rsp[15:8];
  assign adc_select_eff = sel_ok ? st_ff.adc_sel : ADC_SEL_DIE;
  assign invalid_data_flag = !sel_ok;

  a_sel_write: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && cmd_write && cmd_code == CMD_ADC_SEL
    |=> st_ff.adc_sel == $past(cmd_wdata))
    else $error("ADC select write not stored");
  a_ro_words: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && cmd_write && cmd_code == CMD_VIN && !meas_valid
    |=> st_ff.vin == $past(st_ff.vin))
    else $error("Read-only word changed on write");
  a_fast_clear: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && cmd_write && cmd_code == CMD_FAST_STAT && !meas_valid
    |=> (st_ff.fast_stat & $past(cmd_wdata)) == 8'h00)
    else $error("Fast status bit not cleared");
  a_peak_clear: assert property (@(posedge clk) disable iff (!nrst)
    clear_maxima_command && !meas_valid |=> st_ff.vin_max == PEAK_RESET)
    else $error("Input peak not cleared");
  a_peak_hold: assert property (@(posedge clk) disable iff (!nrst)
    !clear_maxima_command |=> st_ff.vout_max[0] >= $past(st_ff.vout_max[0]))
    else $error("Output voltage peak dropped");
  a_bad_sel: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.adc_sel > ADC_SEL_SHORT
    |-> invalid_data_flag && adc_select_eff == ADC_SEL_DIE)
    else $error("Reserved select not forced to die");
  a_read_ans: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && !cmd_write && cmd_code == CMD_VIN
    |=> rsp_valid && {rsp_hi, rsp_lo} == $past(st_ff.vin))
    else $error("Read answer wrong");
  a_iin_total: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && !cmd_write && cmd_code == CMD_IIN_TOTAL
    |=> {rsp_hi, rsp_lo} == $past(st_ff.iin[0] + st_ff.iin[1]))
    else $error("Total input current not the sum");
  a_ecc_upd: assert property (@(posedge clk) disable iff (!nrst)
    ecc_update |=> st_ff.ecc_ok == $past(ecc_clean))
    else $error("ECC status not refreshed");

  // Each stored reading follows results of its own kind and channel only.
  // The channel picked in each check is arbitrary; the random traffic
  // reaches both channels, so one of them is enough to catch a swap.
  a_vin_store: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_VIN |=> st_ff.vin == $past(meas_value))
    else $error("Input voltage reading not stored");
  a_vout_read: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && !cmd_write && cmd_code == CMD_VOUT
    |=> {rsp_hi, rsp_lo} == $past(st_ff.vout[page]))
    else $error("Output voltage read from wrong page");
  a_chan_iin: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_IOUT && !meas_chan
    |=> st_ff.iin[0] == $past(input_current_offset0
                              + mul_hi(meas_value, st_ff.duty[0])))
    else $error("Channel input current not offset plus product");
  a_iout_store: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_IOUT && meas_chan
    |=> st_ff.iout[1] == $past(meas_value))
    else $error("Output current reading not stored");
  a_text_store: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_TEXT && meas_chan
    |=> st_ff.text[1] == $past(meas_value))
    else $error("External temperature reading not stored");
  a_die_alone: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_TDIE
    |=> $stable(st_ff.iout) && $stable(st_ff.text) && $stable(st_ff.iin))
    else $error("Die temperature disturbed another reading");
  a_duty_store: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_DUTY && !meas_chan
    |=> st_ff.duty[0] == $past(meas_value))
    else $error("Duty cycle reading not stored");
  a_freq_store: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_FREQ |=> st_ff.freq == $past(meas_value))
    else $error("Frequency reading not stored");
  a_pout_calc: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_VOUT && meas_chan
    |=> st_ff.pout[1] == $past(mul_hi(meas_value, meas_aux)))
    else $error("Output power not the correlated product");

  // A peak may never sit below a result that has just been taken, even
  // when a clear lands in the same cycle.
  a_vout_peak: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_VOUT && !meas_chan
    |=> st_ff.vout_max[0] >= $past(meas_value))
    else $error("Output voltage peak below reading");
  a_iout_peak: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_IOUT && meas_chan
    |=> st_ff.iout_max[1] >= $past(meas_value))
    else $error("Output current peak below reading");
  a_text_peak: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_TEXT && !meas_chan
    |=> st_ff.text_max[0] >= $past(meas_value))
    else $error("External temperature peak below reading");
  a_die_peak: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_TDIE
    |=> st_ff.tdie_max >= $past(meas_value))
    else $error("Die temperature peak below reading");

  a_sel_keep: assert property (@(posedge clk) disable iff (!nrst)
    !(cmd_valid && cmd_write && cmd_code == CMD_ADC_SEL)
    |=> $stable(st_ff.adc_sel))
    else $error("ADC select changed without a write");
  a_fast_set: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && meas_kind == K_VOUT && !meas_chan
    && st_ff.adc_sel == ADC_SEL_SHORT
    |=> st_ff.fast_stat[0])
    else $error("Fast status bit not set by conversion");
  a_fast_resv: assert property (@(posedge clk) disable iff (!nrst)
    (st_ff.fast_stat & ~FAST_MASK) == 8'h00)
    else $error("Reserved fast status bit set");
  a_info_bits: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && !cmd_write && cmd_code == CMD_INFO
    |=> ({rsp_hi, rsp_lo} & ~(16'h0001 << ECC_BIT)) == 16'h0000
        && rsp_lo[ECC_BIT] == $past(st_ff.ecc_ok))
    else $error("Information word bits wrong");
  a_ecc_hold: assert property (@(posedge clk) disable iff (!nrst)
    !ecc_update |=> $stable(st_ff.ecc_ok))
    else $error("ECC status changed without an update");
  a_write_quiet: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && cmd_write |=> !rsp_valid)
    else $error("Write produced a read answer");
  a_vout_ro: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && cmd_write && cmd_code == CMD_VOUT && !meas_valid
    |=> $stable(st_ff.vout))
    else $error("Output voltage word changed on write");
  a_good_sel: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.adc_sel == ADC_SEL_SHORT || st_ff.adc_sel == ADC_SEL_RR
    |-> !invalid_data_flag && adc_select_eff == st_ff.adc_sel)
    else $error("Valid loop select not passed through");
  a_fast_idle: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.adc_sel != ADC_SEL_SHORT
    |=> (st_ff.fast_stat & ~$past(st_ff.fast_stat)) == 8'h00)
    else $error("Fast status set outside the short loop");
  a_byte_read: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && !cmd_write && cmd_code == CMD_ADC_SEL
    |=> rsp_hi == 8'h00 && rsp_lo == $past(st_ff.adc_sel))
    else $error("Byte register not returned in low byte");
  a_rsp_source: assert property (@(posedge clk) disable iff (!nrst)
    rsp_valid |-> $past(cmd_valid && !cmd_write))
    else $error("Read answer without a read");
endmodule // telemetry_bank

// >>> host_model.sv
// Host model: issues decoded word reads and byte writes to the bank.
// Assumes the bank answers a read within four cycles of taking it.
`timescale 1ns/1ns
module host_model (
  input  wire logic       clk,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_lo,
  input  wire logic [7:0] rsp_hi,
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata
);
  int timeouts = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  // A bounded wait, so a silent bank is reported rather than hanging.
  task automatic rd(input logic [7:0] c, output logic [15:0] w);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b0;
    cmd_code  <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 4);
    if (rsp_valid !== 1'b1) timeouts++;
    w = {rsp_hi, rsp_lo};
  endtask
endmodule // host_model

// >>> pmbus_telemetry_readback_tb.sv
// Self-checking bench for the telemetry bank with random measurements.
// Assumes host_model for command traffic; expectations come from a model.
`timescale 1ns/1ns
module pmbus_telemetry_readback_tb;
  import telemetry_pkg::*;
  logic clk = 0, nrst = 0, page = 0, clear_maxima_command = 0;
  logic meas_valid = 0, meas_chan = 0, ecc_update = 0, ecc_clean = 1;
  logic [3:0] meas_kind = 0;
  logic [15:0] meas_value = 0, meas_aux = 0, w;
  logic [15:0] input_current_offset0 = 0, input_current_offset1 = 0;
  logic cmd_valid, cmd_write, rsp_valid, invalid_data_flag;
  logic [7:0] cmd_code, cmd_wdata, rsp_lo, rsp_hi, adc_select_eff;
  logic [15:0] rdg [7][2] = '{default: '0};
  logic [15:0] pk [7][2] = '{default: '0};
  logic [15:0] pw [2] = '{default: '0};
  logic [15:0] ci [2] = '{default: '0};
  int fail_count = 0, n_checks = 0;
  localparam logic [7:0] RD [7] = '{CMD_VIN, CMD_VOUT, CMD_IOUT,
    CMD_TEMP_EXT, CMD_TEMP_DIE, CMD_DUTY, CMD_FREQ};
  localparam logic [7:0] PK [5] = '{CMD_VIN_MAX, CMD_VOUT_MAX, CMD_IOUT_MAX,
    CMD_TEXT_MAX, CMD_TDIE_MAX};
  always #20 clk = ~clk;
  telemetry_bank dut (.clk, .nrst, .page, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .clear_maxima_command, .meas_valid, .meas_kind, .meas_chan,
    .meas_value, .meas_aux, .input_current_offset0, .input_current_offset1,
    .ecc_update, .ecc_clean, .rsp_valid, .rsp_lo, .rsp_hi, .adc_select_eff,
    .invalid_data_flag);
  host_model host (.clk, .rsp_valid, .rsp_lo, .rsp_hi, .cmd_valid,
    .cmd_write, .cmd_code, .cmd_wdata);
  function automatic logic [15:0] mulhi(logic [15:0] a, logic [15:0] b);
    logic [31:0] p;
    p = a * b;
    return p[31:16];
  endfunction
  function automatic logic rsvd(logic [7:0] c);
    return c == 8'h02 || c == 8'h03 || c == 8'h07 || c == 8'h0B || c > 8'h0D;
  endfunction
  function automatic logic [15:0] eff_of(int c);
    return rsvd(8'(c)) ? 16'(ADC_SEL_DIE) : 16'(c);
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(string nm, logic [7:0] c, logic p, logic [15:0] e);
    page <= p;
    host.rd(c, w);
    chk(nm, e, w);
  endtask
  task automatic meas(int k, logic ch, logic [15:0] v, logic [15:0] a);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_kind  <= 4'(k);
    meas_chan  <= ch;
    meas_value <= v;
    meas_aux   <= a;
    @(posedge clk);
    meas_valid <= 1'b0;
    rdg[k][ch] = v;
    if (v > pk[k][ch]) pk[k][ch] = v;
    if (k == 1) pw[ch] = mulhi(v, a);
    if (k == 2) ci[ch] = (ch ? input_current_offset1 : input_current_offset0)
                         + mulhi(v, rdg[5][ch]);
  endtask
  task automatic pulse_ecc(logic cl);
    @(posedge clk);
    ecc_clean  <= cl;
    ecc_update <= 1'b1;
    @(posedge clk);
    ecc_update <= 1'b0;
  endtask
  task automatic close_out();
    fail_count += host.timeouts;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    int k;
    logic ch, p;
    void'($urandom(20463));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    input_current_offset0 <= 16'($urandom);
    input_current_offset1 <= 16'($urandom);
    rchk("select", CMD_ADC_SEL, 0, {8'h00, ADC_SEL_RESET});
    rchk("info", CMD_INFO, 1, 16'h0020);
    host.wr(8'h00, 8'hFF);
    rchk("unmapped", 8'h00, 0, 16'h0000);
    meas(5, 0, 16'h8000, 0);
    meas(5, 1, 16'hFFFF, 0);
    for (int i = 0; i < 60; i++) begin
      k = $urandom_range(6);
      ch = (k == 0 || k == 4 || k == 6) ? 1'b0 : 1'($urandom_range(1));
      p = (k == 0 || k == 4 || k == 6) ? 1'($urandom_range(1)) : ch;
      meas(k, ch, i < 3 ? 16'hFFFF : 16'($urandom), 16'($urandom));
      host.wr(RD[k], 8'hA5);
      rchk("reading", RD[k], p, rdg[k][ch]);
      if (k < 5) rchk("peak", PK[k], p, pk[k][ch]);
    end
    meas(4, 0, 16'hFFFF, 0);
    for (int c = 0; c < 2; c++) begin
      rchk("chan iin", CMD_IIN_CHAN, 1'(c), ci[c]);
      rchk("power", CMD_POUT, 1'(c), pw[c]);
    end
    rchk("total iin", CMD_IIN_TOTAL, 1, ci[0] + ci[1]);
    @(posedge clk);
    clear_maxima_command <= 1'b1;
    @(posedge clk);
    clear_maxima_command <= 1'b0;
    pk = '{default: '0};
    for (k = 0; k < 5; k++) rchk("cleared", PK[k], 1, 16'h0000);
    meas(3, 1, 16'h0010, 0);
    rchk("ext peak", CMD_TEXT_MAX, 1, 16'h0010);
    for (k = 0; k < 20; k++) begin
      host.wr(CMD_ADC_SEL, 8'(k));
      @(posedge clk);
      chk("eff", eff_of(k), 16'(adc_select_eff));
      chk("flag", 16'(rsvd(8'(k))), 16'(invalid_data_flag));
      rchk("select", CMD_ADC_SEL, 0, 16'(k));
    end
    // A reset in mid-run must bring back the select and the ECC bit.
    pulse_ecc(1'b0);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk("select", CMD_ADC_SEL, 0, {8'h00, ADC_SEL_RESET});
    chk("flag", 16'h0000, 16'(invalid_data_flag));
    rchk("info", CMD_INFO, 0, 16'h0020);
    host.wr(CMD_ADC_SEL, ADC_SEL_SHORT);
    host.wr(CMD_FAST_STAT, 8'h0F);
    meas(1, 1, 16'h1234, 0);
    meas(2, 0, 16'h0042, 0);
    rchk("fast", CMD_FAST_STAT, 0, 16'h0006);
    host.wr(CMD_FAST_STAT, 8'h02);
    rchk("fast", CMD_FAST_STAT, 0, 16'h0004);
    host.wr(CMD_ADC_SEL, ADC_SEL_RR);
    meas(2, 1, 16'h0007, 0);
    rchk("fast", CMD_FAST_STAT, 0, 16'h0004);
    pulse_ecc(1'b0);
    rchk("info", CMD_INFO, 0, 16'h0000);
    pulse_ecc(1'b1);
    rchk("info", CMD_INFO, 0, 16'h0020);
    close_out();
  end
endmodule // pmbus_telemetry_readback_tb
